/* shc_pkg.sv */
package shc_pkg;

  // Register byte offsets of the controller's own AXI4-Lite map.
  localparam logic [3:0] SHC_CTRL_OFS = 4'h0;
  localparam logic [3:0] SHC_STATUS_OFS = 4'h4;
  localparam logic [3:0] SHC_DATA_OFS = 4'h8;

  // Control register field positions.
  localparam int SHC_CTRL_CPOL_BIT = 0;
  localparam int SHC_CTRL_CPHA_BIT = 1;
  localparam int SHC_CTRL_HOLD_BIT = 2;
  localparam int SHC_CTRL_PEER_MASTER_BIT = 3;
  localparam int SHC_CTRL_RX_ONLY_BIT = 4;
  localparam int SHC_CTRL_HALF_LSB = 8;

  // Status register field positions.
  localparam int SHC_STAT_BUSY_BIT = 0;
  localparam int SHC_STAT_DONE_BIT = 1;
  localparam int SHC_STAT_COLL_BIT = 2;

  // Reset values.
  localparam logic [7:0] SHC_CTRL_RESET = 8'h00;
  localparam logic [7:0] SHC_HALF_RESET = 8'h10;

  // AXI4-Lite response codes.
  localparam logic [1:0] SHC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SHC_RESP_SLVERR = 2'h2;

  // Timing: system clock, device clock and the pause between bytes.
  localparam int SHC_CLK_PERIOD_NS = 40;
  localparam int SHC_CLK_HZ = 25_000_000;
  localparam int SHC_DEV_CPU_HZ = 8_000_000;
  localparam int SHC_GAP_NS = 2000;
  localparam int SHC_GAP_CYC = (SHC_GAP_NS + SHC_CLK_PERIOD_NS - 1) / SHC_CLK_PERIOD_NS;
  // A half period long enough that SCK stays at or below half the device clock.
  localparam int SHC_HALF_FROM_DEV = (SHC_CLK_HZ + SHC_DEV_CPU_HZ - 1) / SHC_DEV_CPU_HZ;
  // Three cycles leave room for the two-stage MISO synchroniser.
  localparam int SHC_HALF_SYNC_MIN = 3;
  localparam logic [7:0] SHC_HALF_MIN = 8'((SHC_HALF_FROM_DEV > SHC_HALF_SYNC_MIN) ?
                                          SHC_HALF_FROM_DEV : SHC_HALF_SYNC_MIN);
  localparam int SHC_BYTE_EDGES = 16;
  localparam int SHC_SYNC_DELAY = 2;

  // Transfer sequencer, Gray coded along idle, setup, shift, gap.
  typedef enum logic [1:0] {
    SHC_IDLE = 2'b00,
    SHC_SETUP = 2'b01,
    SHC_SHIFT = 2'b11,
    SHC_GAP = 2'b10
  } shc_state_e;

  // Pins towards the serial device.
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic ss_n;
  } shc_pins_s;

  // Whole state of the controller.
  typedef struct packed {
    shc_state_e fsm;
    logic [4:0] edge_cnt;
    logic [7:0] tick_cnt;
    logic [7:0] gap_cnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rx_buf;
    logic [1:0] cap_pipe;
    logic cpol;
    logic cpha;
    logic hold;
    logic peer_master;
    logic rx_only;
    logic [7:0] half_div;
    logic done_flag;
    logic coll_flag;
    shc_pins_s pins;
    logic miso_s1;
    logic miso_s2;
    logic aw_have;
    logic [3:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } shc_state_s;

endpackage : shc_pkg

/* shc_spi_host.sv */
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module shc_spi_host
  import shc_pkg::*;
#(
  parameter logic [7:0] HALF_MIN = SHC_HALF_MIN,
  parameter logic [7:0] GAP_CYC = 8'(SHC_GAP_CYC)
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // AXI4-Lite write address and data.
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [3:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // AXI4-Lite write response.
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // AXI4-Lite read.
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [3:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // Serial pins towards the device.
  output logic sck_out,
  output logic sck_oe_out,
  output logic mosi_out,
  output logic mosi_oe_out,
  input wire logic miso_in,
  output logic ss_n_out
);

  shc_state_s state_reg;
  shc_state_s state_next;

  // Half period actually used, never shorter than the safe minimum.
  function automatic logic [7:0] shc_half(input logic [7:0] req);
    shc_half = (req < HALF_MIN) ? HALF_MIN : req;
  endfunction : shc_half

  // Tells whether an offset belongs to the register map.
  function automatic logic shc_mapped(input logic [3:0] ofs);
    shc_mapped = (ofs == SHC_CTRL_OFS) || (ofs == SHC_STATUS_OFS) || (ofs == SHC_DATA_OFS);
  endfunction : shc_mapped

  // Read value of one register.
  function automatic logic [31:0] shc_read(input shc_state_s s, input logic [3:0] ofs);
    logic [31:0] v;
    v = 32'h0;
    case (ofs)
      SHC_CTRL_OFS: begin
        v[SHC_CTRL_CPOL_BIT] = s.cpol;
        v[SHC_CTRL_CPHA_BIT] = s.cpha;
        v[SHC_CTRL_HOLD_BIT] = s.hold;
        v[SHC_CTRL_PEER_MASTER_BIT] = s.peer_master;
        v[SHC_CTRL_RX_ONLY_BIT] = s.rx_only;
        v[SHC_CTRL_HALF_LSB +: 8] = s.half_div;
      end
      SHC_STATUS_OFS: begin
        v[SHC_STAT_BUSY_BIT] = (s.fsm != SHC_IDLE);
        v[SHC_STAT_DONE_BIT] = s.done_flag;
        v[SHC_STAT_COLL_BIT] = s.coll_flag;
      end
      SHC_DATA_OFS: v[7:0] = s.rx_buf;
      default: v = 32'h0;
    endcase
    shc_read = v;
  endfunction : shc_read

  // Next-state logic for the bus slave and the serial sequencer.
  always_comb begin
    logic do_write;
    logic tick;
    logic capture_edge;
    logic shift_edge;
    logic start_req;
    logic set_done;
    logic set_coll;
    logic clr_done;
    logic clr_coll;
    do_write = 1'b0;
    tick = 1'b0;
    capture_edge = 1'b0;
    shift_edge = 1'b0;
    start_req = 1'b0;
    set_done = 1'b0;
    set_coll = 1'b0;
    clr_done = 1'b0;
    clr_coll = 1'b0;
    state_next = state_reg;

    // Two-stage synchroniser; only the second stage is read below.
    state_next.miso_s1 = miso_in;
    state_next.miso_s2 = state_reg.miso_s1;

    // Address and data are taken in either order, then answered together.
    if (awvalid_in && state_reg.awready) begin
      state_next.aw_have = 1'b1;
      state_next.awaddr = awaddr_in;
    end
    if (wvalid_in && state_reg.wready) begin
      state_next.w_have = 1'b1;
      state_next.wdata = wdata_in;
      state_next.wstrb = wstrb_in;
    end
    if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
      do_write = 1'b1;
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = shc_mapped(state_reg.awaddr) ? SHC_RESP_OKAY : SHC_RESP_SLVERR;
    end else if (state_reg.bvalid && bready_in) begin
      state_next.bvalid = 1'b0;
    end
    state_next.awready = !state_next.aw_have && !state_next.bvalid;
    state_next.wready = !state_next.w_have && !state_next.bvalid;

    // Register writes; byte lanes without a strobe are left alone.
    if (do_write) begin
      case (state_reg.awaddr)
        SHC_CTRL_OFS: begin
          if (state_reg.wstrb[0]) begin
            state_next.cpol = state_reg.wdata[SHC_CTRL_CPOL_BIT];
            state_next.cpha = state_reg.wdata[SHC_CTRL_CPHA_BIT];
            state_next.hold = state_reg.wdata[SHC_CTRL_HOLD_BIT];
            state_next.peer_master = state_reg.wdata[SHC_CTRL_PEER_MASTER_BIT];
            state_next.rx_only = state_reg.wdata[SHC_CTRL_RX_ONLY_BIT];
          end
          if (state_reg.wstrb[1]) begin
            state_next.half_div = state_reg.wdata[SHC_CTRL_HALF_LSB +: 8];
          end
        end
        SHC_STATUS_OFS: begin
          if (state_reg.wstrb[0]) begin
            clr_done = state_reg.wdata[SHC_STAT_DONE_BIT];
            clr_coll = state_reg.wdata[SHC_STAT_COLL_BIT];
          end
        end
        SHC_DATA_OFS: begin
          if (state_reg.wstrb[0]) begin
            // Only we start a byte, and never while the device is master.
            if (state_reg.fsm == SHC_IDLE && !state_reg.peer_master) begin
              start_req = 1'b1;
            end else begin
              set_coll = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // Read channel: one read at a time, answered one cycle after acceptance.
    if (arvalid_in && state_reg.arready) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rdata = shc_read(state_reg, araddr_in);
      state_next.rresp = shc_mapped(araddr_in) ? SHC_RESP_OKAY : SHC_RESP_SLVERR;
    end else if (state_reg.rvalid && rready_in) begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end

    // Half-period timer paces every SCK edge.
    if (state_reg.fsm == SHC_SHIFT) begin
      if (state_reg.tick_cnt == shc_half(state_reg.half_div) - 8'h01) begin
        tick = 1'b1;
        state_next.tick_cnt = 8'h00;
      end else begin
        state_next.tick_cnt = state_reg.tick_cnt + 8'h01;
      end
    end else begin
      state_next.tick_cnt = 8'h00;
    end

    // Even edges lead, odd edges trail; phase picks which one captures.
    if (tick && state_reg.edge_cnt < 5'(SHC_BYTE_EDGES)) begin
      capture_edge = (state_reg.edge_cnt[0] == state_reg.cpha);
      shift_edge = !capture_edge && (state_reg.edge_cnt != 5'(SHC_BYTE_EDGES - 1));
      state_next.pins.sck = !state_reg.pins.sck;
      state_next.edge_cnt = state_reg.edge_cnt + 5'h01;
    end

    // Sample MISO once the synchroniser has caught up with the edge.
    state_next.cap_pipe = {state_reg.cap_pipe[0], capture_edge};
    if (state_reg.cap_pipe[SHC_SYNC_DELAY - 1]) begin
      state_next.rx = {state_reg.rx[6:0], state_reg.miso_s2};
    end

    // Sequencer.
    case (state_reg.fsm)
      SHC_IDLE: begin
        state_next.pins.sck = state_reg.cpol;
        state_next.edge_cnt = 5'h00;
        // Select rests high unless held low for continuous phase-one traffic.
        state_next.pins.ss_n = !(state_reg.hold && state_reg.cpha) || state_reg.peer_master;
        if (start_req) begin
          state_next.tx = state_reg.wdata[7:0];
          state_next.pins.ss_n = 1'b0;
          state_next.fsm = SHC_SETUP;
        end
      end
      SHC_SETUP: begin
        // Phase zero needs the first bit on the line before the first edge.
        if (!state_reg.cpha) begin
          state_next.pins.mosi = state_reg.tx[7];
          state_next.tx = {state_reg.tx[6:0], 1'b0};
        end
        state_next.fsm = SHC_SHIFT;
      end
      SHC_SHIFT: begin
        if (shift_edge) begin
          state_next.pins.mosi = state_reg.tx[7];
          state_next.tx = {state_reg.tx[6:0], 1'b0};
        end
        // One more half period after the last edge closes the byte.
        if (tick && state_reg.edge_cnt == 5'(SHC_BYTE_EDGES)) begin
          state_next.rx_buf = state_reg.rx;
          set_done = 1'b1;
          state_next.gap_cnt = 8'h00;
          // Phase zero must see select rise between bytes.
          state_next.pins.ss_n = !(state_reg.hold && state_reg.cpha);
          state_next.fsm = SHC_GAP;
        end
      end
      SHC_GAP: begin
        // Give the device time to clear its flags and reload.
        if (state_reg.gap_cnt >= GAP_CYC - 8'h01) begin
          state_next.fsm = SHC_IDLE;
        end else begin
          state_next.gap_cnt = state_reg.gap_cnt + 8'h01;
        end
      end
      default: state_next.fsm = SHC_IDLE;
    endcase

    // While the device is master we release its clock and data lines.
    state_next.pins.sck_oe = !state_next.peer_master;
    // A shared single data line carries one direction only.
    state_next.pins.mosi_oe = !state_next.peer_master && !state_next.rx_only;
    if (state_next.peer_master) begin
      state_next.pins.ss_n = 1'b1;
    end

    // Sticky flags: a new event beats a clear in the same cycle.
    state_next.done_flag = set_done || (state_reg.done_flag && !clr_done);
    state_next.coll_flag = set_coll || (state_reg.coll_flag && !clr_coll);
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
      state_reg.fsm <= SHC_IDLE;
      state_reg.cpol <= SHC_CTRL_RESET[SHC_CTRL_CPOL_BIT];
      state_reg.cpha <= SHC_CTRL_RESET[SHC_CTRL_CPHA_BIT];
      state_reg.half_div <= SHC_HALF_RESET;
      state_reg.pins.ss_n <= 1'b1;
      state_reg.pins.sck_oe <= 1'b1;
      state_reg.pins.mosi_oe <= 1'b1;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a flip-flop of the state.
  assign awready_out = state_reg.awready;
  assign wready_out = state_reg.wready;
  assign bvalid_out = state_reg.bvalid;
  assign bresp_out = state_reg.bresp;
  assign arready_out = state_reg.arready;
  assign rvalid_out = state_reg.rvalid;
  assign rdata_out = state_reg.rdata;
  assign rresp_out = state_reg.rresp;
  assign sck_out = state_reg.pins.sck;
  assign sck_oe_out = state_reg.pins.sck_oe;
  assign mosi_out = state_reg.pins.mosi;
  assign mosi_oe_out = state_reg.pins.mosi_oe;
  assign ss_n_out = state_reg.pins.ss_n;

endmodule : shc_spi_host

/* shc_spi_host_asserts.sv */
`timescale 1ns/1ns
module shc_spi_host_asserts #(
  parameter logic [7:0] HALF_MIN = 8'h04,
  parameter logic [7:0] GAP_CYC = 8'h04
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Register bus handshakes.
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic [31:0] rdata_out,
  // Serial pins.
  input wire logic sck_out,
  input wire logic sck_oe_out,
  input wire logic mosi_oe_out,
  input wire logic ss_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic sck_q;
  logic [4:0] edge_cnt;
  logic [15:0] low_cnt;
  // Counts toggles and cycles of one select-low stretch; the gap parameter is kept for binding.
  always_ff @(posedge clk_in) begin
    sck_q <= sck_out;
    if (rst_in || ss_n_out) begin
      edge_cnt <= 5'h00;
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
      edge_cnt <= edge_cnt + 5'(sck_out != sck_q);
    end
  end
  property p_bvalid_hold;
    bvalid_out && !bready_in |=> bvalid_out;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
  property p_rvalid_hold;
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data not held");
  property p_write_answer;
    awvalid_in && awready_out && wvalid_in && wready_out |-> ##[1:2] bvalid_out;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write answer");
  property p_read_answer;
    arvalid_in && arready_out |=> !arready_out ##[0:1] rvalid_out;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read answer");
  property p_sck_half;
    $changed(sck_out) |=> $stable(sck_out)[*3];
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("serial clock too fast");
  property p_byte_edges;
    $rose(ss_n_out) |-> edge_cnt == 5'h10 && low_cnt >= 16'(16 * HALF_MIN);
  endproperty
  a_byte_edges: assert property (p_byte_edges) else $error("byte not 16 edges");
  property p_gap;
    $rose(ss_n_out) |=> ss_n_out[*3];
  endproperty
  a_gap: assert property (p_gap) else $error("select not high between bytes");
  property p_peer_ss;
    !sck_oe_out |-> ss_n_out && !mosi_oe_out;
  endproperty
  a_peer_ss: assert property (p_peer_ss) else $error("select low beside peer master");
  c_byte: cover property ($rose(ss_n_out));
  c_peer: cover property (!sck_oe_out);
  c_write: cover property (bvalid_out && bready_in);
endmodule : shc_spi_host_asserts
bind shc_spi_host shc_spi_host_asserts #(.HALF_MIN(HALF_MIN), .GAP_CYC(GAP_CYC))
  u_shc_spi_host_asserts (.clk_in, .rst_in, .awvalid_in, .awready_out, .wvalid_in,
  .wready_out, .bvalid_out, .bready_in, .arvalid_in, .arready_out, .rvalid_out,
  .rready_in, .rdata_out, .sck_out, .sck_oe_out, .mosi_oe_out, .ss_n_out);

/* shc_dev_model.sv */
`timescale 1ns/1ns
module shc_dev_model (
  // Serial pins seen from the device.
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  // Mode and reply set by the bench.
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic [7:0] reply_in,
  output logic [7:0] got_out
);
  logic [7:0] tx_sh;
  initial miso_out = 1'b0;
  // Select low loads the reply; with phase zero the first bit must be out before any edge.
  always @(negedge ss_n_in) begin
    tx_sh = reply_in;
    if (!cpha_in) begin
      miso_out = tx_sh[7];
      tx_sh = {tx_sh[6:0], 1'b0};
    end
  end
  // Slave takes the clock as input: sample on one edge, drive on the other.
  always @(sck_in) begin
    if (!ss_n_in && ((sck_in != cpol_in) != cpha_in)) begin
      got_out = {got_out[6:0], mosi_in};
    end else if (!ss_n_in) begin
      miso_out = tx_sh[7];
      tx_sh = {tx_sh[6:0], 1'b0};
    end
  end
  // A released data line has no pull, so it must not keep the last bit.
  always @(posedge ss_n_in) miso_out = ~miso_out;
endmodule : shc_dev_model

/* test_shc_spi_host.sv */
`timescale 1ns/1ns
module test_shc_spi_host
  import shc_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
  logic arvalid_in = 1'b0, rready_in = 1'b0, mosi_w = 1'b0, m_cpol = 1'b0, m_cpha = 1'b0;
  logic [3:0] awaddr_in = 4'h0, araddr_in = 4'h0, wstrb_in = 4'hf;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_in, ss_n_out;
  logic [1:0] bresp_out, rresp_out;
  logic [7:0] reply = 8'h00, got;
  logic [34:0] qr[$];
  logic [1:0] qb[$];
  int n_errors = 0, cmp_count = 0, seed = 32'h8a6b9175;
  always #20 clk_in = ~clk_in;
  shc_spi_host #(.HALF_MIN(8'h04), .GAP_CYC(8'h04)) u_shc_spi_host (.*);
  shc_dev_model u_shc_dev_model (.sck_in(sck_out), .ss_n_in(ss_n_out), .mosi_in(mosi_w),
    .miso_out(miso_in), .cpol_in(m_cpol), .cpha_in(m_cpha), .reply_in(reply), .got_out(got));
  // Released MOSI floats, so the wire shows the inverse of its last level.
  always @(posedge clk_in) mosi_w <= mosi_oe_out ? mosi_out : ~mosi_w;
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Compares each bus answer with the oldest expectation noted by the driver.
  always @(posedge clk_in) begin
    logic [34:0] e_r;
    if (bvalid_out && bready_in && qb.size() > 0) begin
      check("bresp", 32'(qb.pop_front()), 32'(bresp_out));
    end
    if (rvalid_out && rready_in && qr.size() > 0) begin
      e_r = qr.pop_front();
      check("rresp", 32'(e_r[33:32]), 32'(rresp_out));
      if (e_r[34]) check("rdata", e_r[31:0], rdata_out);
    end
  end
  // One idle edge ends each cycle so no signal is assigned twice in one step.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    qb.push_back(r);
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk_in);
      if (awvalid_in && awready_out) awvalid_in <= 1'b0;
      if (wvalid_in && wready_out) wvalid_in <= 1'b0;
      if (bvalid_out) break;
    end
    bready_in <= 1'b0;
    @(posedge clk_in);
    if (k == 200) begin
      n_errors++;
      print_verdict();
    end
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [34:0] e, output logic [31:0] d);
    int k;
    qr.push_back(e);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'b0;
      if (rvalid_out) break;
    end
    d = rdata_out;
    rready_in <= 1'b0;
    @(posedge clk_in);
    if (k == 200) begin
      n_errors++;
      print_verdict();
    end
  endtask : axr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axr(a, {1'b1, SHC_RESP_OKAY, exp}, d);
  endtask : rd
  // Polls status; polling reads check only the response code.
  task automatic wait_done;
    int k;
    logic [31:0] s;
    for (k = 0; k < 100; k++) begin
      axr(SHC_STATUS_OFS, {1'b0, SHC_RESP_OKAY, 32'h0}, s);
      if (s[SHC_STAT_DONE_BIT] && !s[SHC_STAT_BUSY_BIT]) break;
    end
    if (k == 100) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_done
  task automatic xfer(input logic [7:0] t, input logic chk_mosi);
    logic [7:0] r;
    r = 8'($random(seed));
    reply <= r;
    axw(SHC_DATA_OFS, {24'h0, t}, SHC_RESP_OKAY);
    wait_done();
    if (chk_mosi) check("device byte", {24'h0, t}, {24'h0, got});
    rd(SHC_DATA_OFS, {24'h0, r});
    axw(SHC_STATUS_OFS, 32'h6, SHC_RESP_OKAY);
    rd(SHC_STATUS_OFS, 32'h0);
  endtask : xfer
  // Main sequence: registers, all four modes plus receive-only, collision, peer master.
  initial begin
    int m;
    logic [31:0] c;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(SHC_CTRL_OFS, {16'h0, SHC_HALF_RESET, SHC_CTRL_RESET});
    rd(SHC_STATUS_OFS, 32'h0);
    axw(4'hc, 32'h1, SHC_RESP_SLVERR);
    axr(4'hc, {1'b0, SHC_RESP_SLVERR, 32'h0}, c);
    $display("test registers done");
    for (m = 0; m < 5; m++) begin
      c = {16'h0, 8'h04, 3'h0, 1'(m == 4), 2'h0, 2'(m)};
      m_cpol <= c[SHC_CTRL_CPOL_BIT];
      m_cpha <= c[SHC_CTRL_CPHA_BIT];
      axw(SHC_CTRL_OFS, c, SHC_RESP_OKAY);
      rd(SHC_CTRL_OFS, c);
      check("mosi enable", {31'h0, m != 4}, {31'h0, mosi_oe_out});
      xfer(8'($random(seed)), m != 4);
    end
    $display("test modes done");
    m_cpol <= 1'b0;
    m_cpha <= 1'b0;
    axw(SHC_CTRL_OFS, 32'h00000400, SHC_RESP_OKAY);
    c = {24'h0, 8'($random(seed))};
    axw(SHC_DATA_OFS, c, SHC_RESP_OKAY);
    axw(SHC_DATA_OFS, {24'h0, ~c[7:0]}, SHC_RESP_OKAY);
    wait_done();
    check("device byte", c, {24'h0, got});
    rd(SHC_STATUS_OFS, 32'h6);
    axw(SHC_STATUS_OFS, 32'h6, SHC_RESP_OKAY);
    $display("test collision done");
    axw(SHC_CTRL_OFS, 32'h00000408, SHC_RESP_OKAY);
    check("sck enable", 32'h0, {31'h0, sck_oe_out});
    check("mosi enable", 32'h0, {31'h0, mosi_oe_out});
    axw(SHC_DATA_OFS, 32'h5a, SHC_RESP_OKAY);
    check("select", 32'h1, {31'h0, ss_n_out});
    rd(SHC_STATUS_OFS, 32'h4);
    $display("test peer done");
    print_verdict();
  end
endmodule : test_shc_spi_host
